// [include/sef_pkg.sv]
// constants and types for the serial eeprom select/clock front end
// assumes a 200 MHz system clock sampling the serial pins synchronously
package sef_pkg;

  ////////////////////////////////////////////////////////////////////////
  // clock and self-timed cycle lengths
  localparam int CLK_MHZ         = 200;
  localparam int WORD_PROG_US    = 2000;   // erase+write of one word
  localparam int ERASE_CYCLE_US  = 1000;   // erase_cycle_time
  localparam int ALL_PROG_US     = 15000;  // erase_all / write_all
  localparam int WORD_PROG_CYC   = WORD_PROG_US * CLK_MHZ;
  localparam int ERASE_CYCLE_CYC = ERASE_CYCLE_US * CLK_MHZ;
  localparam int ALL_PROG_CYC    = ALL_PROG_US * CLK_MHZ;
  localparam int TMR_W           = 22;

  ////////////////////////////////////////////////////////////////////////
  // array geometry and frame layout
  localparam int WORDS     = 16;
  localparam int WORD_W    = 16;
  localparam int ADDR_W    = 4;
  localparam int OP_W      = 4;
  localparam int CNT_W     = 5;
  localparam logic [CNT_W-1:0] HDR_LAST  = 5'h07;  // opcode+address bits - 1
  localparam logic [CNT_W-1:0] DATA_LAST = 5'h0f;
  localparam logic [CNT_W-1:0] RD_BITS   = 5'h10;
  localparam logic [WORD_W-1:0] ERASED   = 16'hffff;

  ////////////////////////////////////////////////////////////////////////
  // opcodes
  localparam logic [OP_W-1:0] OP_READ     = 4'h8;
  localparam logic [OP_W-1:0] OP_WRITE    = 4'h4;
  localparam logic [OP_W-1:0] OP_ERASE    = 4'hc;
  localparam logic [OP_W-1:0] OP_WR_EN    = 4'h3;
  localparam logic [OP_W-1:0] OP_WR_DIS   = 4'h0;
  localparam logic [OP_W-1:0] OP_ERASE_AL = 4'h2;
  localparam logic [OP_W-1:0] OP_WRITE_AL = 4'h1;

  typedef enum logic [2:0] {
    ST_WAIT  = 3'b000,
    ST_HDR   = 3'b001,
    ST_DATA  = 3'b010,
    ST_READ  = 3'b011,
    ST_DONE  = 3'b100
  } sef_state_t;

  typedef enum logic [1:0] {
    PK_WORD  = 2'b00,
    PK_ERASE = 2'b01,
    PK_ALL   = 2'b10
  } sef_kind_t;

  // serial pins from the master
  typedef struct packed {
    logic sel;
    logic sclk;
    logic serial_in;
  } sef_pins_t;

  // programming request to the cycle timer
  typedef struct packed {
    logic      start;
    sef_kind_t kind;
  } sef_prog_t;

endpackage

// [src/sef_prog_timer.sv]
// self-timed programming cycle counter
// assumes one start pulse per cycle, never while busy
`timescale 1ns/1ps
module sef_prog_timer
  import sef_pkg::*;
#(
  parameter int WORD_CYC  = WORD_PROG_CYC,
  parameter int ERASE_CYC = ERASE_CYCLE_CYC,
  parameter int ALL_CYC   = ALL_PROG_CYC
) (
  // clock and reset
  input  wire logic      ref_clk_i,
  input  wire logic      srst_i,
  // request
  input  wire sef_prog_t req_i,
  // status
  output logic           busy_o,
  output logic           done_o
);

  logic [TMR_W-1:0] cnt_r;

  function automatic logic [TMR_W-1:0] load_of(input sef_kind_t k);
    case (k)
      PK_WORD:  load_of = TMR_W'(WORD_CYC - 1);
      PK_ERASE: load_of = TMR_W'(ERASE_CYC - 1);
      PK_ALL:   load_of = TMR_W'(ALL_CYC - 1);
      default:  load_of = TMR_W'(WORD_CYC - 1);
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // internal time base, no serial clock needed
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      cnt_r  <= '0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (req_i.start && !busy_o) begin
        cnt_r  <= load_of(req_i.kind);
        busy_o <= 1'b1;
      end else if (busy_o) begin
        if (cnt_r == '0) begin
          busy_o <= 1'b0;
          done_o <= 1'b1;
        end else begin
          cnt_r <= cnt_r - 1'b1;
        end
      end
    end
  end

endmodule

// [src/sef_frontend.sv]
// serial eeprom front end: select, clock sampling, shifting, array, status
// assumes select, clock and serial input are synchronous to ref_clk_i
`timescale 1ns/1ps
// Function
// - select high selects; low means standby unless programming
// - programming finishes regardless of select
// - select low resets instruction logic
// - input bits sampled on clock rising edge
// - output bits advance on clock rising edge
// - halted clock loses no state
// - clock ignored while select low
// - before start bit, clocks change nothing
// - program cycle timed internally, no clocks
// - after last bit, ignore until select low
// - start, opcode, address, data in order
// - word program 2 ms; all 15 ms
// - array is sixteen sixteen-bit words
// - start bit is first edge select&input high; the code ignores such an edge while programming
// - read gives dummy zero, then MSB first
// - powers up write-disabled
// - reselect after program shows busy, ready
module sef_frontend
  import sef_pkg::*;
#(
  parameter int WORD_CYC  = WORD_PROG_CYC,
  parameter int ERASE_CYC = ERASE_CYCLE_CYC,
  parameter int ALL_CYC   = ALL_PROG_CYC
) (
  // clock and reset
  input  wire logic      ref_clk_i,
  input  wire logic      srst_i,
  // serial pins from the master
  input  wire sef_pins_t pins_i,
  // serial output pin
  output logic           serial_out_o,
  output logic           serial_out_oe_o,
  // device state
  output logic           standby_o,
  output logic           prog_busy_o
);

  ////////////////////////////////////////////////////////////////////////
  // declarations
  logic [WORD_W-1:0] mem_r [WORDS];
  sef_state_t        st_r;
  logic [CNT_W-1:0]  cnt_r;
  logic [7:0]        hdr_r;
  logic [WORD_W-1:0] data_r;
  logic [WORD_W-1:0] rd_r;
  logic              rd_bit_r;
  logic              rd_oe_r;
  logic              sclk_q_r;
  logic              wr_en_r;
  logic              seen_low_r;
  sef_prog_t         req_r;
  logic [ADDR_W-1:0] prog_addr_r;
  logic [WORD_W-1:0] prog_data_r;
  logic [OP_W-1:0]   prog_op_r;
  logic              tmr_busy;
  logic              tmr_done;
  logic              rise;
  logic              prog_active;
  logic [7:0]        hdr_full;
  logic [OP_W-1:0]   op;
  logic [ADDR_W-1:0] addr;

  function automatic sef_kind_t kind_of(input logic [OP_W-1:0] o);
    case (o)
      OP_ERASE:    kind_of = PK_ERASE;
      OP_ERASE_AL: kind_of = PK_ALL;
      OP_WRITE_AL: kind_of = PK_ALL;
      default:     kind_of = PK_WORD;
    endcase
  endfunction

  function automatic logic needs_data(input logic [OP_W-1:0] o);
    needs_data = (o == OP_WRITE) || (o == OP_WRITE_AL);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // clock edge detect, gated by select
  assign rise        = pins_i.sel && pins_i.sclk && !sclk_q_r;
  assign prog_active = tmr_busy || req_r.start;
  assign hdr_full    = {hdr_r[6:0], pins_i.serial_in};
  assign op          = hdr_full[7:4];
  assign addr        = hdr_full[3:0];

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      sclk_q_r <= 1'b0;
    end else begin
      sclk_q_r <= pins_i.sclk;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // instruction sequencer
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      st_r        <= ST_WAIT;
      cnt_r       <= '0;
      hdr_r       <= '0;
      data_r      <= '0;
      rd_r        <= '0;
      rd_bit_r    <= 1'b0;
      rd_oe_r     <= 1'b0;
      wr_en_r     <= 1'b0;
      req_r       <= '{start: 1'b0, kind: PK_WORD};
      prog_addr_r <= '0;
      prog_data_r <= '0;
      prog_op_r   <= '0;
    end else begin
      req_r.start <= 1'b0;
      if (!pins_i.sel) begin
        st_r    <= ST_WAIT;
        cnt_r   <= '0;
        rd_oe_r <= 1'b0;
      end else if (rise) begin
        case (st_r)
          ST_WAIT: begin
            if (pins_i.serial_in && !prog_active) begin
              st_r  <= ST_HDR;
              cnt_r <= '0;
            end
          end
          ST_HDR: begin
            hdr_r <= hdr_full;
            cnt_r <= cnt_r + 1'b1;
            if (cnt_r == HDR_LAST) begin
              cnt_r       <= '0;
              prog_addr_r <= addr;
              prog_op_r   <= op;
              if (op == OP_READ) begin
                rd_r     <= mem_r[addr];
                rd_bit_r <= 1'b0;
                rd_oe_r  <= 1'b1;
                st_r     <= ST_READ;
              end else if (needs_data(op)) begin
                st_r <= ST_DATA;
              end else begin
                st_r <= ST_DONE;
                if (op == OP_WR_EN) begin
                  wr_en_r <= 1'b1;
                end else if (op == OP_WR_DIS) begin
                  wr_en_r <= 1'b0;
                end else if (wr_en_r && (kind_of(op) != PK_WORD)) begin
                  // undefined opcodes start no cycle
                  req_r <= '{start: 1'b1, kind: kind_of(op)};
                end
              end
            end
          end
          ST_DATA: begin
            data_r <= {data_r[WORD_W-2:0], pins_i.serial_in};
            cnt_r  <= cnt_r + 1'b1;
            if (cnt_r == DATA_LAST) begin
              st_r        <= ST_DONE;
              prog_data_r <= {data_r[WORD_W-2:0], pins_i.serial_in};
              if (wr_en_r) begin
                req_r <= '{start: 1'b1, kind: kind_of(prog_op_r)};
              end
            end
          end
          ST_READ: begin
            if (cnt_r == RD_BITS) begin
              rd_oe_r <= 1'b0;
              st_r    <= ST_DONE;
            end else begin
              rd_bit_r <= rd_r[WORD_W-1];
              rd_r     <= {rd_r[WORD_W-2:0], 1'b0};
              cnt_r    <= cnt_r + 1'b1;
            end
          end
          ST_DONE: begin
            st_r <= ST_DONE;
          end
          default: begin
            st_r <= ST_WAIT;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // self-timed cycle
  sef_prog_timer #(
    .WORD_CYC  (WORD_CYC),
    .ERASE_CYC (ERASE_CYC),
    .ALL_CYC   (ALL_CYC)
  ) u_timer (
    .ref_clk_i (ref_clk_i),
    .srst_i    (srst_i),
    .req_i     (req_r),
    .busy_o    (tmr_busy),
    .done_o    (tmr_done)
  );

  ////////////////////////////////////////////////////////////////////////
  // array update at cycle end, select not consulted
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      for (int i = 0; i < WORDS; i++) begin
        mem_r[i] <= ERASED;
      end
    end else if (tmr_done) begin
      for (int i = 0; i < WORDS; i++) begin
        case (prog_op_r)
          OP_WRITE:    if (prog_addr_r == ADDR_W'(i)) mem_r[i] <= prog_data_r;
          OP_ERASE:    if (prog_addr_r == ADDR_W'(i)) mem_r[i] <= ERASED;
          OP_ERASE_AL: mem_r[i] <= ERASED;
          OP_WRITE_AL: mem_r[i] <= mem_r[i] & prog_data_r;
          default:     mem_r[i] <= mem_r[i];
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // status window: select dropped during cycle, then raised
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      seen_low_r <= 1'b0;
    end else if (!pins_i.sel && prog_active) begin
      seen_low_r <= 1'b1;
    end else if (!pins_i.sel) begin
      seen_low_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registered pin and state outputs
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      serial_out_o    <= 1'b0;
      serial_out_oe_o <= 1'b0;
      standby_o       <= 1'b1;
      prog_busy_o     <= 1'b0;
    end else begin
      prog_busy_o <= prog_active;
      standby_o   <= !pins_i.sel && !prog_active;
      if (pins_i.sel && seen_low_r) begin
        serial_out_o    <= !prog_active;
        serial_out_oe_o <= 1'b1;
      end else begin
        serial_out_o    <= rd_bit_r;
        serial_out_oe_o <= rd_oe_r && pins_i.sel;
      end
    end
  end

endmodule

// [bench/sef_frontend_chk.sv]
// checker for the serial eeprom front end top ports
// assumes the bind below; program counts shortened to at most 100 cycles
`timescale 1ns/1ps
module sef_frontend_chk
  import sef_pkg::*;
(
  // clock and reset
  input wire logic      ref_clk_i,
  input wire logic      srst_i,
  // pins
  input wire sef_pins_t pins_i,
  input wire logic      serial_out_o,
  input wire logic      serial_out_oe_o,
  // state
  input wire logic      standby_o,
  input wire logic      prog_busy_o
);
  localparam int BUSY_MAX = 104;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);
  ////////////////////////////////////////////////////////////////////////
  a_sel_high_active: assert property (pins_i.sel |=> !standby_o)
    else $error("standby while selected");
  a_busy_holds: assert property ($rose(prog_busy_o) |-> prog_busy_o[*8])
    else $error("program cycle cut short");
  a_busy_bounded: assert property ($rose(prog_busy_o) |-> ##[1:BUSY_MAX] !prog_busy_o)
    else $error("program cycle too long");
  a_desel_no_prog: assert property ((!pins_i.sel)[*2] |=> !$rose(prog_busy_o))
    else $error("program started while deselected");
  a_desel_released: assert property ((!pins_i.sel && !prog_busy_o)[*3] |-> !serial_out_oe_o)
    else $error("output driven while deselected");
  a_busy_status: assert property ($rose(serial_out_oe_o) && prog_busy_o |-> !serial_out_o)
    else $error("status not busy");
  a_out_on_rise: assert property (serial_out_oe_o && $past(serial_out_oe_o) && $changed(serial_out_o)
    && !$past(prog_busy_o) && !$past(prog_busy_o, 2) && !$past(prog_busy_o, 3)
    |-> $past(pins_i.sclk, 2) && !$past(pins_i.sclk, 3))
    else $error("output changed without clock rise");
  a_halt_stable: assert property ((pins_i.sel && serial_out_oe_o && !prog_busy_o
    && $stable(pins_i.sclk))[*5] |-> $stable(serial_out_o))
    else $error("output moved while clock halted");
endmodule
bind sef_frontend sef_frontend_chk u_chk (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .pins_i(pins_i),
  .serial_out_o(serial_out_o), .serial_out_oe_o(serial_out_oe_o), .standby_o(standby_o),
  .prog_busy_o(prog_busy_o));

// [bench/sef_master.sv]
// master model driving select, clock and serial input
// assumes the caller waits on ref_clk_i; serial out seen with pull-up
`timescale 1ns/1ps
module sef_master
  import sef_pkg::*;
(
  // clock and serial out level
  input  wire logic ref_clk_i,
  input  wire logic so_i,
  // pins to the device
  output sef_pins_t pins_o
);
  int   stall = 0;
  logic sel_v = 1'b1;
  initial pins_o = '0;
  // one bit: low phase with data, then high phase
  task automatic clk_bit(input logic b);
    repeat (1 + stall) @(posedge ref_clk_i) pins_o <= '{sel: sel_v, sclk: 1'b0, serial_in: b};
    repeat (1 + stall) @(posedge ref_clk_i) pins_o.sclk <= 1'b1;
  endtask
  task automatic send(input logic [24:0] v, input int n);
    for (int i = 24; i > 24 - n; i--) clk_bit(v[i]);
  endtask
  task automatic hold(input logic s, input int n);
    repeat (n) @(posedge ref_clk_i) pins_o <= '{sel: s, sclk: 1'b0, serial_in: 1'b0};
  endtask
  task automatic rd_bit(output logic b);
    clk_bit(1'b0);
    repeat (3) @(posedge ref_clk_i);
    #1 b = so_i;
  endtask
endmodule

// [bench/serial_eeprom_select_clock_frontend_tb.sv]
// self-checking bench for the serial eeprom front end
// assumes shortened program counts and the master model
`timescale 1ns/1ps
module serial_eeprom_select_clock_frontend_tb
  import sef_pkg::*;
;
  localparam int WC = 40;
  localparam int EC = 20;
  localparam int AC = 100;
  logic      ref_clk_i = 1'b0;
  logic      srst_i = 1'b1;
  sef_pins_t pins;
  logic      so, so_oe, stby, busy;
  wire       so_lvl = so_oe ? so : 1'b1;
  int        bad_count = 0;
  int        checks = 0;
  always #2.5 ref_clk_i = ~ref_clk_i;
  sef_frontend #(.WORD_CYC(WC), .ERASE_CYC(EC), .ALL_CYC(AC)) dut (.ref_clk_i(ref_clk_i),
    .srst_i(srst_i), .pins_i(pins), .serial_out_o(so), .serial_out_oe_o(so_oe),
    .standby_o(stby), .prog_busy_o(busy));
  sef_master m (.ref_clk_i(ref_clk_i), .so_i(so_lvl), .pins_o(pins));
  ////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic frame(input logic [3:0] op, input logic [3:0] a, input logic [15:0] d, int n);
    m.send({1'b1, op, a, d}, n);
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    logic [15:0] got;
    logic        b;
    frame(OP_READ, a, 16'h0000, 9);
    repeat (2) @(posedge ref_clk_i);
    #1 chk(so_oe, 1'b1);
    chk(so_lvl, 1'b0);
    for (int i = 15; i >= 0; i--) begin
      m.rd_bit(b);
      got[i] = b;
    end
    chk(got, exp);
    m.rd_bit(b);
    chk(so_oe, 1'b0);
    m.hold(1'b0, 21);
  endtask
  task automatic prog_wait(input int lo, input int hi, input logic st);
    int w = 0;
    int n = 0;
    while (busy !== 1'b1 && w < 8) begin
      @(posedge ref_clk_i) #1 w++;
    end
    while (busy === 1'b1 && n < 200) begin
      @(posedge ref_clk_i) #1 n++;
    end
    chk(16'(n >= lo && n <= hi), 16'h0001);
    if (w == 8 || n == 200) begin
      bad_count++;
      report_and_stop();
    end
    // still selected: ready status only if select dropped during the cycle
    @(posedge ref_clk_i);
    #1 chk(so_oe, st);
    chk(so_lvl, 1'b1);
    m.hold(1'b0, 21);
    #1 chk(stby, 1'b1);
  endtask
  task automatic no_prog;
    repeat (6) @(posedge ref_clk_i);
    #1 chk(busy, 1'b0);
    m.hold(1'b0, 21);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    #1 chk(stby, 1'b1);
    chk(so_oe, 1'b0);
    m.hold(1'b1, 3);
    #1 chk(stby, 1'b0);
    $display("reset test done");
  endtask
  task automatic t_wait_start;
    m.send(25'h0, 24);
    #1 chk(so_oe, 1'b0);
    rd(4'h5, 16'hffff);
    $display("start test done");
  endtask
  task automatic t_write;
    frame(OP_WRITE, 4'h3, 16'h1234, 25);
    no_prog();
    frame(OP_WR_EN, 4'h0, 16'h0000, 9);
    m.hold(1'b0, 21);
    frame(OP_WRITE, 4'h3, 16'ha5c3, 25);
    m.hold(1'b0, 21);
    #1 chk(stby, 1'b0);
    m.hold(1'b1, 2);
    #1 chk(so_oe, 1'b1);
    chk(so_lvl, 1'b0);
    chk(busy, 1'b1);
    prog_wait(1, WC, 1'b1);
    m.hold(1'b1, 3);
    #1 chk(so_oe, 1'b0);
    m.hold(1'b0, 21);
    m.stall = 2;
    rd(4'h3, 16'ha5c3);
    m.stall = 0;
    $display("write test done");
  endtask
  task automatic t_abort;
    m.send({1'b1, OP_READ, 2'b00, 18'h0}, 7);
    m.hold(1'b0, 21);
    m.sel_v = 1'b0;
    frame(OP_ERASE, 4'h3, 16'h0000, 9);
    m.sel_v = 1'b1;
    no_prog();
    rd(4'h3, 16'ha5c3);
    $display("abort test done");
  endtask
  task automatic t_program;
    frame(OP_ERASE, 4'h3, 16'h0000, 9);
    prog_wait(EC, EC + 3, 1'b0);
    rd(4'h3, 16'hffff);
    frame(OP_WRITE_AL, 4'h0, 16'h0f0f, 25);
    prog_wait(AC, AC + 3, 1'b0);
    rd(4'h9, 16'h0f0f);
    frame(OP_ERASE_AL, 4'h0, 16'h0000, 9);
    prog_wait(AC, AC + 3, 1'b0);
    frame(OP_WRITE, 4'h9, 16'h3c3c, 25);
    prog_wait(WC, WC + 3, 1'b0);
    frame(OP_WR_EN, 4'h0, 16'h0000, 9);
    frame(OP_ERASE, 4'h9, 16'h0000, 9);
    no_prog();
    frame(OP_WR_DIS, 4'h0, 16'h0000, 9);
    m.hold(1'b0, 21);
    frame(OP_ERASE, 4'h9, 16'h0000, 9);
    no_prog();
    rd(4'h9, 16'h3c3c);
    $display("program test done");
  endtask
  initial begin
    repeat (10) @(posedge ref_clk_i);
    srst_i <= 1'b0;
    @(posedge ref_clk_i);
    t_reset();
    t_wait_start();
    t_write();
    t_abort();
    t_program();
    report_and_stop();
  end
endmodule
